// [rtl/spi_cfg_pkg.sv]
// package: constants shared by both ends of the configuration link
package spi_cfg_pkg;
    localparam int FRAME_BITS = 16;
    localparam logic [4:0] ADDR_FAULT_FIRST = 5'h00;
    localparam logic [4:0] ADDR_FAULT_SECOND = 5'h01;
    localparam logic [4:0] ADDR_BANK_SELECT = 5'h03;
    localparam logic [4:0] ADDR_BANK_COMMIT = 5'h04;
    localparam logic [4:0] ADDR_SLOT_X = 5'h05;
    localparam logic [4:0] ADDR_SLOT_Y = 5'h06;
    localparam logic [4:0] ADDR_SLOT_Z = 5'h07;
    localparam logic [7:0] CFG_BANK_FIRST = 8'h18;
    localparam logic [7:0] CFG_BANK_LAST = 8'h1F;
    localparam logic [7:0] NVM_BANK_FIRST = 8'h08;
    localparam logic [7:0] NVM_BANK_LAST = 8'h0F;
    localparam logic [7:0] NVM_BANK_OFFSET = 8'h10;
    localparam logic [7:0] COMMIT_VALUE = 8'h00;
    localparam int CFG_COUNT = 23;
    localparam int NVM_COUNT = 8;
    localparam int KEY_COUNT = 7;
    localparam logic [7:0] CFG_RESET [CFG_COUNT] = '{
        8'h08, 8'hF0, 8'h50, 8'hCF, 8'h26, 8'h0E, 8'h08, 8'h03, 8'h00, 8'h07, 8'h05, 8'h02,
        8'h01, 8'h13, 8'h00, 8'h00, 8'h00, 8'h1F, 8'h1F, 8'h00, 8'h00, 8'h1F, 8'h03};
    localparam logic [19:0] UNLOCK_KEY [KEY_COUNT] = '{
        20'h7C339, 20'h71C7D, 20'h650FE, 20'h9E0E1, 20'h7A13F, 20'h5B393, 20'h60604};
    localparam logic [7:0] FAULT_RESET = 8'h00;
    localparam logic [7:0] FIRST_STATUS_MASK = 8'h40; // status bit, not latched
    localparam logic [7:0] SECOND_STATUS_MASK = 8'h43;
    localparam logic [7:0] SECOND_RESERVED_MASK = 8'h08;
    localparam logic [3:0] CLK_DIV_HALF = 4'h4; // master sck half period in clk cycles
endpackage

// [rtl/spi_cfg_if.sv]
// interface: four-wire serial link between the master and the device
interface spi_cfg_if;
    logic sck;
    logic select_n;
    logic mosi;
    logic miso_o;
    logic miso_oe;
    logic miso;
    assign miso = miso_oe ? miso_o : 1'b1;
    modport device (input sck, input select_n, input mosi, output miso_o, output miso_oe);
    modport master (output sck, output select_n, output mosi, input miso);
endinterface

// [rtl/spi_cfg_device.sv]
// device end: serial slave, fault reporting and indirect configuration bank
// Summary of operation
// R1: master sets odd parity across frame
// R2: output bit advances on falling sck
// R3: fault summary flag out at select fall
// R4: nvm error bit reported every frame
// R5: bad-parity write discarded, serial error set
// R6: bad-parity read also sets serial error
// R7: fault registers directly addressed
// R8: status bits follow live fault condition
// R9: writing one clears latched fault bit
// R10: bank select copies triple to slots
// R11: slots plain access; zero commit stores
// R12: banks 18..1F ascending, X highest
// R13: nvm image 32 bits, low 24 used
// R14: nvm bank is config bank minus 10
// R15: nvm writes need seven-key unlock
// R16: keys fixed order, any deviation locks
// R17: unlock only as first transfers
// R18: master writes zeros to reserved
// R19: frame addr, w/r, data, parity
// R20: read returns register with diagnostics
// R21: sixteen edges required; else serial error
// R22: latched bit survives clear while active
// R23: unknown bank leaves slots unchanged
module spi_cfg_device (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    spi_cfg_if.device LINK,
    input wire logic [7:0] FAULT_FIRST_IN,
    input wire logic [7:0] FAULT_SECOND_IN,
    input wire logic NVM_ERROR,
    output logic [spi_cfg_pkg::CFG_COUNT*8-1:0] CFG_OUT,
    output logic NVM_WRITE_EN
);
    import spi_cfg_pkg::*;

    typedef struct packed {
        logic [1:0] sck_s;
        logic [1:0] sel_s;
        logic [1:0] mosi_s;
        logic sck_d;
        logic sel_d;
        logic [19:0] rx; // twenty bits so a whole unlock key fits
        logic [5:0] cnt;
        logic [15:0] tx;
        logic miso;
        logic oe;
        logic serr;
        logic [7:0] flt0;
        logic [7:0] flt1;
        logic [7:0] bank;
        logic [7:0] sx;
        logic [7:0] sy;
        logic [7:0] sz;
        logic [CFG_COUNT*8-1:0] cfg;
        logic [NVM_COUNT*32-1:0] nvm;
        logic [2:0] key_idx;
        logic key_live;
        logic unlocked;
    } state_type;

    state_type s_r, s_nxt;

    // parity and frame fields
    logic [7:0] rd_val;
    logic odd_ok, frame_ok;
    logic [4:0] f_addr;
    logic f_wr;
    logic [7:0] f_data;
    logic [7:0] fa_live;
    logic [7:0] fb_live;
    int base;

    assign fa_live = FAULT_FIRST_IN;
    assign fb_live = FAULT_SECOND_IN & ~SECOND_RESERVED_MASK;
    assign f_addr = s_r.rx[15:11];
    assign f_wr = s_r.rx[10];
    assign f_data = s_r.rx[8:1];
    assign odd_ok = ^s_r.rx[15:0]; // [R1] [R5] [R6]
    assign frame_ok = odd_ok && (s_r.cnt == 6'(FRAME_BITS)); // [R21]

    // register read mux on the address of the frame being sent
    function automatic logic [7:0] read_mux(input state_type s, input logic [4:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            ADDR_FAULT_FIRST: v = {|(s.flt0[6:0] | s.flt1), s.flt0[6:0]}; // [R7]
            ADDR_FAULT_SECOND: v = s.flt1; // [R7]
            ADDR_BANK_SELECT: v = s.bank;
            ADDR_SLOT_X: v = s.sx;
            ADDR_SLOT_Y: v = s.sy;
            ADDR_SLOT_Z: v = s.sz;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    always_comb begin
        logic fall, rise, sel_fall, sel_rise, ff;
        logic [15:0] frame;
        logic [7:0] idx;
        s_nxt = s_r;
        fall = 1'b0;
        rise = 1'b0;
        sel_fall = 1'b0;
        sel_rise = 1'b0;
        ff = 1'b0;
        frame = 16'h0000;
        idx = 8'h00;
        base = 0;
        rd_val = 8'h00;
        // pins pass two flops before any use
        s_nxt.sck_s = {s_r.sck_s[0], LINK.sck};
        s_nxt.sel_s = {s_r.sel_s[0], LINK.select_n};
        s_nxt.mosi_s = {s_r.mosi_s[0], LINK.mosi};
        s_nxt.sck_d = s_r.sck_s[1];
        s_nxt.sel_d = s_r.sel_s[1];
        rise = s_r.sck_s[1] && !s_r.sck_d;
        fall = !s_r.sck_s[1] && s_r.sck_d;
        sel_fall = !s_r.sel_s[1] && s_r.sel_d;
        sel_rise = s_r.sel_s[1] && !s_r.sel_d;
        // status bits track live faults, latched bits set on fault
        s_nxt.flt0 = (s_r.flt0 & ~FIRST_STATUS_MASK) | fa_live; // [R8]
        s_nxt.flt1 = (s_r.flt1 & ~SECOND_STATUS_MASK) | fb_live; // [R8]
        ff = |(s_nxt.flt0[6:0] | s_nxt.flt1);
        if (sel_fall) begin
            // load diagnostic frame; serial error from previous transaction
            frame = {ff, NVM_ERROR, s_r.serr, s_r.flt0[5], s_r.flt0[4], s_r.flt0[2],
                     s_r.flt1[1], s_r.flt0[3], s_r.flt1[4], 1'b0, s_r.flt1[2],
                     s_r.flt1[0], 3'b000, 1'b0}; // [R3] [R4]
            frame[0] = ~^frame[15:1];
            s_nxt.tx = frame;
            s_nxt.miso = frame[15]; // [R3]
            s_nxt.oe = 1'b1;
            s_nxt.cnt = 6'h00;
            s_nxt.rx = 20'h00000;
        end else if (!s_r.sel_s[1]) begin
            if (rise) begin
                s_nxt.rx = {s_r.rx[18:0], s_r.mosi_s[1]}; // [R19]
                if (s_r.cnt != 6'h3F) s_nxt.cnt = s_r.cnt + 6'h01;
                // sixth rise brings the w/r bit; address sits in rx[4:0]
                if (s_r.cnt == 6'h05 && !s_r.mosi_s[1]) begin
                    rd_val = read_mux(s_r, s_r.rx[4:0]); // [R20]
                    // six bits already gone out, so data bits 8:1 now sit at 14:7
                    s_nxt.tx[14:7] = rd_val;
                    // parity fixed by difference: the sent high bits are no longer held
                    s_nxt.tx[6] = s_r.tx[6] ^ (^s_r.tx[14:7]) ^ (^rd_val);
                end
            end
            if (fall) begin
                s_nxt.tx = {s_r.tx[14:0], 1'b0};
                s_nxt.miso = s_r.tx[14]; // [R2]
            end
        end
        if (sel_rise) begin
            s_nxt.oe = 1'b0;
            s_nxt.serr = !frame_ok; // [R5] [R6] [R21]
            // key tracking: only the first frames after reset may unlock
            if (s_r.key_live && !s_r.unlocked) begin
                // all twenty bits must match, so a near miss cannot unlock
                if (s_r.cnt == 6'h14 && s_r.rx == UNLOCK_KEY[s_r.key_idx]) begin
                    if (s_r.key_idx == 3'(KEY_COUNT - 1)) s_nxt.unlocked = 1'b1; // [R15] [R16]
                    else s_nxt.key_idx = s_r.key_idx + 3'h1;
                end else begin
                    s_nxt.key_live = 1'b0; // [R17]
                end
            end
            if (frame_ok && f_wr) begin
                s_nxt.key_live = s_nxt.key_live && (s_r.cnt == 6'd20);
                unique case (f_addr)
                    ADDR_FAULT_FIRST: s_nxt.flt0 = (s_r.flt0 & ~f_data) | fa_live; // [R9] [R22]
                    ADDR_FAULT_SECOND: s_nxt.flt1 = (s_r.flt1 & ~f_data) | fb_live; // [R9] [R22]
                    ADDR_BANK_SELECT: begin
                        s_nxt.bank = f_data;
                        if (f_data >= CFG_BANK_FIRST && f_data <= CFG_BANK_LAST) begin
                            idx = f_data - CFG_BANK_FIRST;
                            base = int'(idx) * 3; // [R12]
                            s_nxt.sz = s_r.cfg[base*8 +: 8];
                            s_nxt.sy = s_r.cfg[(base+1)*8 +: 8];
                            s_nxt.sx = (idx == 8'h07) ? 8'h00 : s_r.cfg[(base+2)*8 +: 8]; // [R10]
                        end else if (f_data >= NVM_BANK_FIRST && f_data <= NVM_BANK_LAST) begin
                            idx = f_data - NVM_BANK_FIRST; // [R14]
                            {s_nxt.sx, s_nxt.sy, s_nxt.sz} = s_r.nvm[int'(idx)*32 +: 24]; // [R13]
                        end // [R23]
                    end
                    ADDR_BANK_COMMIT: begin
                        if (f_data == COMMIT_VALUE) begin // [R11]
                            if (s_r.bank >= CFG_BANK_FIRST && s_r.bank <= CFG_BANK_LAST) begin
                                idx = s_r.bank - CFG_BANK_FIRST;
                                base = int'(idx) * 3;
                                s_nxt.cfg[base*8 +: 8] = s_r.sz;
                                s_nxt.cfg[(base+1)*8 +: 8] = s_r.sy;
                                if (idx != 8'h07) s_nxt.cfg[(base+2)*8 +: 8] = s_r.sx;
                            end else if (s_r.bank >= NVM_BANK_FIRST && s_r.bank <= NVM_BANK_LAST
                                && s_r.unlocked) begin // [R15]
                                idx = s_r.bank - NVM_BANK_FIRST;
                                s_nxt.nvm[int'(idx)*32 +: 24] = {s_r.sx, s_r.sy, s_r.sz};
                            end
                        end
                    end
                    ADDR_SLOT_X: s_nxt.sx = f_data; // [R11]
                    ADDR_SLOT_Y: s_nxt.sy = f_data;
                    ADDR_SLOT_Z: s_nxt.sz = f_data;
                    default: ;
                endcase
            end else if (frame_ok) begin
                s_nxt.key_live = 1'b0;
            end
        end
    end

    // reset values; nvm images start as the configuration defaults
    function automatic state_type reset_state();
        state_type r;
        r = '0;
        r.sck_s = 2'b11;
        r.sel_s = 2'b11;
        r.sck_d = 1'b1;
        r.sel_d = 1'b1;
        r.miso = 1'b1;
        r.flt0 = FAULT_RESET;
        r.flt1 = FAULT_RESET;
        r.key_live = 1'b1;
        for (int i = 0; i < CFG_COUNT; i++) r.cfg[i*8 +: 8] = CFG_RESET[i];
        for (int j = 0; j < CFG_COUNT; j++) r.nvm[(j/3)*32 + (j%3)*8 +: 8] = CFG_RESET[j];
        return r;
    endfunction

    // folded to a constant so the reset branch loads a fixed value
    localparam state_type RESET_STATE = reset_state();

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) s_r <= RESET_STATE;
        else if (CE) s_r <= s_nxt;
    end

    assign LINK.miso_o = s_r.miso;
    assign LINK.miso_oe = s_r.oe;
    assign CFG_OUT = s_r.cfg;
    assign NVM_WRITE_EN = s_r.unlocked;
endmodule

// [rtl/spi_cfg_master.sv]
// master end: APB-controlled serial frame engine
module spi_cfg_master (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    spi_cfg_if.master LINK,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);
    import spi_cfg_pkg::*;

    // register map of the master: 0x00 tx word, 0x04 control, 0x08 rx word, 0x0C status
    localparam logic [7:0] REG_TX = 8'h00;
    localparam logic [7:0] REG_CTRL = 8'h04;
    localparam logic [7:0] REG_RX = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0C;

    typedef enum logic [1:0] {IDLE, SETUP, SHIFT, HOLD} phase_type;

    typedef struct packed {
        phase_type ph;
        logic [19:0] txw;
        logic [4:0] nbits;
        logic auto_par;
        logic [19:0] sh;
        logic [4:0] left;
        logic [15:0] rxw;
        logic [3:0] div;
        logic sck;
        logic seln;
        logic mosi;
        logic [1:0] miso_s;
    } state_type;

    state_type s_r, s_nxt;
    logic wr_acc;

    assign wr_acc = PSEL && PENABLE && PWRITE;

    always_comb begin
        logic [19:0] w;
        s_nxt = s_r;
        w = 20'h0;
        s_nxt.miso_s = {s_r.miso_s[0], LINK.miso};
        if (wr_acc && PADDR == REG_TX) s_nxt.txw = PWDATA[19:0];
        if (wr_acc && PADDR == REG_CTRL && s_r.ph == IDLE && PWDATA[0]) begin
            // bit0 start, bit1 auto parity, bits 8..12 length (20 starts at word bit 19, any other length at bit 15)
            s_nxt.nbits = PWDATA[12:8];
            s_nxt.auto_par = PWDATA[1];
            w = s_r.txw;
            if (PWDATA[1]) w[0] = ~^w[15:1]; // [R1]
            s_nxt.sh = (PWDATA[12:8] == 5'd20) ? w : {w[15:0], 4'h0};
            s_nxt.left = PWDATA[12:8];
            s_nxt.seln = 1'b0;
            s_nxt.div = 4'h0;
            s_nxt.ph = SETUP;
        end
        unique case (s_r.ph)
            IDLE: ;
            SETUP, SHIFT: begin
                s_nxt.div = s_r.div + 4'h1;
                if (s_r.div == CLK_DIV_HALF - 4'h1) begin
                    s_nxt.div = 4'h0;
                    if (s_r.sck) begin
                        // falling edge: drive next bit
                        if (s_r.left == 5'h0) begin
                            s_nxt.ph = HOLD;
                        end else begin
                            s_nxt.sck = 1'b0;
                            s_nxt.mosi = s_r.sh[19];
                            s_nxt.sh = {s_r.sh[18:0], 1'b0};
                            s_nxt.ph = SHIFT;
                        end
                    end else begin
                        s_nxt.sck = 1'b1; // sample on rising edge
                        s_nxt.rxw = {s_r.rxw[14:0], s_r.miso_s[1]};
                        s_nxt.left = s_r.left - 5'h1;
                    end
                end
            end
            HOLD: begin
                s_nxt.seln = 1'b1; // sck stays high at select change [R21]
                s_nxt.ph = IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s_r <= '{ph: IDLE, sck: 1'b1, seln: 1'b1, miso_s: 2'b11, default: '0};
        end else if (CE) begin
            s_r <= s_nxt;
        end
    end

    always_comb begin
        unique case (PADDR)
            REG_TX: PRDATA = {12'h000, s_r.txw};
            REG_CTRL: PRDATA = {19'h0, s_r.nbits, 6'h0, s_r.auto_par, 1'b0};
            REG_RX: PRDATA = {16'h0000, s_r.rxw};
            REG_STAT: PRDATA = {31'h0, s_r.ph != IDLE};
            default: PRDATA = 32'h0000_0000;
        endcase
    end
    assign PREADY = 1'b1;
    assign PSLVERR = 1'b0;
    assign LINK.sck = s_r.sck;
    assign LINK.select_n = s_r.seln;
    assign LINK.mosi = s_r.mosi;
endmodule

// [verification/spi_cfg_props.sv]
// checker: timing relations on the serial link wires between both ends
module spi_cfg_props (
    input wire logic CLK,
    input wire logic RST,
    input wire logic sck,
    input wire logic select_n,
    input wire logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [4:0] rises;
        logic [3:0] since;
        logic sck_q;
        logic sel_q;
    } mon_type;
    mon_type st_r;
    mon_type st_nxt;
    ////////////////////////////////////////
    // rising sck count per frame, cycles since last falling sck or select change
    always_comb begin
        st_nxt = st_r;
        st_nxt.sck_q = sck;
        st_nxt.sel_q = select_n;
        if (st_r.since != 4'hF) begin
            st_nxt.since = st_r.since + 4'h1;
        end
        // only falling sck and select changes restart it, so a change four or more cycles after a rise is caught
        if ((!sck && st_r.sck_q) || (select_n != st_r.sel_q)) begin
            st_nxt.since = 4'h0;
        end
        if (!select_n && st_r.sel_q) begin
            st_nxt.rises = 5'h00;
        end else if (!select_n && sck && !st_r.sck_q) begin
            st_nxt.rises = st_r.rises + 5'h01;
        end
    end
    // helper state register
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st_r <= '{rises: 5'h00, since: 4'hF, sck_q: 1'b1, sel_q: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    AST_OE_AFTER_SELECT: assert property ($fell(select_n) |-> ##[1:4] miso_oe)
        else $error("miso not driven after select fall");
    AST_OE_OFF_IDLE: assert property ((select_n)[*5] |-> !miso_oe)
        else $error("miso driven while not selected");
    AST_OE_HELD_IN_FRAME: assert property ((!select_n)[*5] |-> miso_oe)
        else $error("miso released inside frame");
    AST_MISO_ON_FALL: assert property (miso_oe && $changed(miso_o) |-> st_r.since <= 4'h6)
        else $error("miso moved away from falling sck");
    AST_SCK_HIGH_AT_SELECT: assert property ($changed(select_n) |-> sck && $past(sck))
        else $error("sck low while select changes");
    AST_SCK_LOW_HALF: assert property ($fell(sck) |-> (!sck)[*4] ##1 sck)
        else $error("sck low phase not four cycles");
    AST_MOSI_STABLE_RISE: assert property ($rose(sck) |-> $stable(mosi))
        else $error("mosi changed at rising sck");
    AST_RISE_COUNT: assert property ($rose(select_n) |-> st_r.rises inside {[15:20]})
        else $error("frame edge count out of range");
    cover property ($rose(select_n) && st_r.rises == 5'd20);
    cover property ($rose(select_n) && st_r.rises == 5'd16);
    cover property ($rose(select_n) && st_r.rises == 5'd15);
endmodule

// [verification/testbench.sv]
// testbench: both link ends joined, driven over the master's register bus
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin fail_count++; \
    $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import spi_cfg_pkg::*;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prd;
    logic pready;
    logic [7:0] ff1 = 8'h00;
    logic [7:0] ff2 = 8'h00;
    logic nvm_err = 1'b0;
    logic nvm_we;
    logic [CFG_COUNT*8-1:0] cfg_out;
    logic [15:0] r;
    int fail_count = 0;
    int cmp_count = 0;
    int i;
    spi_cfg_if link();
    spi_cfg_device spi_cfg_device_inst (.CLK(CLK), .RST(RST), .CE(1'b1), .LINK(link),
        .FAULT_FIRST_IN(ff1), .FAULT_SECOND_IN(ff2), .NVM_ERROR(nvm_err),
        .CFG_OUT(cfg_out), .NVM_WRITE_EN(nvm_we));
    spi_cfg_master spi_cfg_master_inst (.CLK(CLK), .RST(RST), .CE(1'b1), .LINK(link),
        .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwd),
        .PRDATA(prd), .PREADY(pready), .PSLVERR());
    spi_cfg_props spi_cfg_props_inst (.CLK(CLK), .RST(RST), .sck(link.sck),
        .select_n(link.select_n), .mosi(link.mosi), .miso_o(link.miso_o),
        .miso_oe(link.miso_oe));
    ////////////////////////////////////////
    // clock and a hang guard
    always #25 CLK = ~CLK;
    initial begin
        #3000000;
        fail_count++;
        tally_and_finish();
    end
    ////////////////////////////////////////
    // one bus transfer; request held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge CLK);
        pen <= 1'b1;
        // no wait count assumed: only the watchdog ends a stuck access
        do begin
            @(posedge CLK);
        end while (pready !== 1'b1);
        q = prd;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge CLK);
    endtask
    // odd parity over the whole frame
    function automatic logic [15:0] mk(input logic [4:0] a, input logic w, input logic [7:0] d);
        logic [15:0] f;
        f = {a, w, 1'b0, d, 1'b0};
        f[0] = ~^f[15:1];
        return f;
    endfunction
    // load word, start frame of n bits, wait for select to close, fetch reply
    task automatic xfer(input logic [19:0] w, input logic [4:0] n, output logic [15:0] q);
        logic [31:0] d;
        int k;
        apb(1'b1, 8'h00, {12'h000, w}, d);
        apb(1'b1, 8'h04, {19'h0, n, 8'h01}, d);
        k = 0;
        while (link.select_n !== 1'b0 && k < 100) begin
            @(posedge CLK);
            k++;
        end
        while (link.select_n !== 1'b1 && k < 800) begin
            @(posedge CLK);
            k++;
        end
        `CHK("frame end", 1'b1, link.select_n)
        repeat (8) @(posedge CLK);
        apb(1'b0, 8'h08, 32'h0, d);
        q = d[15:0];
    endtask
    task automatic rw(input logic [4:0] a, input logic w, input logic [7:0] d,
        output logic [15:0] q);
        xfer({4'h0, mk(a, w, d)}, 5'd16, q);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (16) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        for (i = 0; i < KEY_COUNT; i++) xfer(UNLOCK_KEY[i], 5'd20, r);
        `CHK("unlock", 1'b1, nvm_we)
        rw(ADDR_BANK_SELECT, 1'b1, NVM_BANK_FIRST, r);
        rw(ADDR_SLOT_X, 1'b1, 8'h77, r);
        rw(ADDR_BANK_COMMIT, 1'b1, COMMIT_VALUE, r);
        rw(ADDR_BANK_SELECT, 1'b1, CFG_BANK_FIRST, r);
        rw(ADDR_SLOT_X, 1'b0, 8'h00, r);
        `CHK("cfg x", CFG_RESET[2], r[8:1])
        rw(ADDR_BANK_SELECT, 1'b1, NVM_BANK_FIRST, r);
        rw(ADDR_SLOT_X, 1'b0, 8'h00, r);
        `CHK("nvm x", 8'h77, r[8:1])
        $display("test unlock done");
        // second reset: keys after another transfer must stay locked
        RST <= 1'b1;
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        rw(ADDR_FAULT_FIRST, 1'b0, 8'h00, r);
        for (i = 0; i < KEY_COUNT; i++) xfer(UNLOCK_KEY[i], 5'd20, r);
        `CHK("late keys", 1'b0, nvm_we)
        rw(ADDR_BANK_SELECT, 1'b1, 8'h09, r);
        rw(ADDR_SLOT_X, 1'b1, 8'h55, r);
        rw(ADDR_BANK_COMMIT, 1'b1, COMMIT_VALUE, r);
        rw(ADDR_BANK_SELECT, 1'b1, 8'h09, r);
        rw(ADDR_SLOT_X, 1'b0, 8'h00, r);
        `CHK("locked nvm", CFG_RESET[5], r[8:1])
        for (i = 0; i < CFG_COUNT; i++) `CHK("cfg reset", CFG_RESET[i], cfg_out[8*i+:8])
        for (i = 0; i < 8; i++) begin
            rw(ADDR_BANK_SELECT, 1'b1, CFG_BANK_FIRST + 8'(i), r);
            rw(ADDR_SLOT_Z, 1'b0, 8'h00, r);
            `CHK("slot z", CFG_RESET[3*i], r[8:1])
            rw(ADDR_SLOT_Y, 1'b0, 8'h00, r);
            `CHK("slot y", CFG_RESET[3*i+1], r[8:1])
            if (i < 7) begin
                rw(ADDR_SLOT_X, 1'b0, 8'h00, r);
                `CHK("slot x", CFG_RESET[3*i+2], r[8:1])
            end
        end
        rw(ADDR_BANK_SELECT, 1'b1, NVM_BANK_LAST, r);
        rw(ADDR_SLOT_Y, 1'b0, 8'h00, r);
        `CHK("nvm y", CFG_RESET[22], r[8:1])
        rw(ADDR_BANK_SELECT, 1'b1, 8'h20, r);
        rw(ADDR_SLOT_Y, 1'b0, 8'h00, r);
        `CHK("bad bank", CFG_RESET[22], r[8:1])
        `CHK("flags", 3'b000, r[15:13])
        $display("test banks done");
        // commit, then a bad-parity write that must be dropped
        rw(ADDR_BANK_SELECT, 1'b1, 8'h1E, r);
        rw(ADDR_SLOT_Z, 1'b1, 8'h0A, r);
        rw(ADDR_BANK_COMMIT, 1'b1, COMMIT_VALUE, r);
        `CHK("commit", 8'h0A, cfg_out[18*8+:8])
        xfer({4'h0, mk(ADDR_SLOT_Z, 1'b1, 8'h15) ^ 16'h0001}, 5'd16, r);
        rw(ADDR_BANK_COMMIT, 1'b1, COMMIT_VALUE, r);
        `CHK("wr serr", 1'b1, r[13])
        `CHK("wr kept", 8'h0A, cfg_out[18*8+:8])
        xfer({4'h0, mk(ADDR_FAULT_FIRST, 1'b0, 8'h00) ^ 16'h0001}, 5'd16, r);
        rw(ADDR_FAULT_FIRST, 1'b0, 8'h00, r);
        `CHK("rd serr", 1'b1, r[13])
        xfer({4'h0, mk(ADDR_SLOT_Z, 1'b1, 8'h33)}, 5'd15, r);
        rw(ADDR_SLOT_Z, 1'b0, 8'h00, r);
        `CHK("count serr", 1'b1, r[13])
        `CHK("count kept", 8'h0A, r[8:1])
        rw(ADDR_SLOT_Z, 1'b0, 8'h00, r);
        `CHK("serr gone", 1'b0, r[13])
        $display("test errors done");
        // latched, status and still-active faults
        ff1 <= 8'h01;
        repeat (4) @(posedge CLK);
        ff1 <= 8'h00;
        rw(ADDR_FAULT_FIRST, 1'b0, 8'h00, r);
        `CHK("latched", 2'b11, {r[15], r[1]})
        rw(ADDR_FAULT_FIRST, 1'b1, 8'h01, r);
        rw(ADDR_FAULT_FIRST, 1'b0, 8'h00, r);
        `CHK("cleared", 9'h000, {r[15], r[8:1]})
        ff1 <= 8'h40;
        rw(ADDR_FAULT_FIRST, 1'b0, 8'h00, r);
        `CHK("status on", 1'b1, r[7])
        ff1 <= 8'h00;
        rw(ADDR_FAULT_FIRST, 1'b0, 8'h00, r);
        `CHK("status off", 1'b0, r[7])
        ff1 <= 8'h01;
        rw(ADDR_FAULT_FIRST, 1'b1, 8'hFF, r);
        rw(ADDR_FAULT_FIRST, 1'b0, 8'h00, r);
        `CHK("still set", 1'b1, r[1])
        ff1 <= 8'h00;
        rw(ADDR_FAULT_FIRST, 1'b1, 8'hFF, r);
        rw(ADDR_FAULT_FIRST, 1'b0, 8'h00, r);
        `CHK("all clear", 8'h00, r[8:1])
        ff2 <= 8'h80;
        repeat (4) @(posedge CLK);
        ff2 <= 8'h00;
        rw(ADDR_FAULT_SECOND, 1'b0, 8'h00, r);
        `CHK("second set", 1'b1, r[8])
        rw(ADDR_FAULT_SECOND, 1'b1, 8'hFF, r);
        rw(ADDR_FAULT_SECOND, 1'b0, 8'h00, r);
        `CHK("second clr", 8'h00, r[8:1])
        nvm_err <= 1'b1;
        rw(ADDR_SLOT_Z, 1'b0, 8'h00, r);
        `CHK("ee read", 1'b1, r[14])
        rw(ADDR_BANK_SELECT, 1'b1, 8'h20, r);
        `CHK("ee write", 1'b1, r[14])
        nvm_err <= 1'b0;
        $display("test faults done");
        // third reset: a first key wrong only in its top bit must not unlock
        RST <= 1'b1;
        repeat (2) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        xfer(UNLOCK_KEY[0] ^ 20'h80000, 5'd20, r);
        for (i = 1; i < KEY_COUNT; i++) xfer(UNLOCK_KEY[i], 5'd20, r);
        `CHK("bad key", 1'b0, nvm_we)
        $display("test keys done");
        tally_and_finish();
    end
endmodule
